// >>> hdl/fhm_monitor_bank.sv
/*
  Fault history and maintenance monitor bank, APB slave.
  Assumes fault, hour-tick, run and wear-tick inputs come from logic on pclk,
  so they are used without synchronisers; ticks are one-cycle pulses.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module fhm_monitor_bank (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fault_valid,
  input  wire logic [15:0] fault_code,
  input  wire logic        hour_tick,
  input  wire logic        run_active,
  input  wire logic        run_cmd_pulse,
  input  wire logic        fan_running,
  input  wire logic        cap_wear_tick,
  input  wire logic        relay_wear_tick,
  input  wire logic        switch_wear_tick
);

  // Index match; byte lanes below the word are required to be zero
  function automatic logic idx_hit(input logic [17:0] addr, input logic [15:0] idx);
    idx_hit = (addr[17:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  logic [15:0]                hist_reg [fhm_pkg::HIST_DEPTH];
  logic [16:0]                hrs_reg  [fhm_pkg::HIST_DEPTH];
  logic [16:0]                op_hours_reg;
  logic [15:0]                run_count_reg;
  logic [15:0]                fan_hours_reg;
  logic [15:0]                cap_life_reg;
  logic [15:0]                relay_life_reg;
  logic [15:0]                switch_life_reg;
  fhm_pkg::fhm_count_mode_t   mode_reg;
  logic [31:0]                prdata_reg;
  logic                       pslverr_reg;
  logic [31:0]                rdata_next;
  logic                       hit_next;
  logic                       wr_en;
  logic                       wr_ctrl;
  logic                       wr_op_preset;
  logic                       wr_fan_preset;
  logic                       run_clr;
  logic                       cap_clr;
  logic                       relay_clr;
  logic                       switch_clr;
  logic                       op_inc;
  logic                       fan_inc;
  logic [16:0]                op_hours_next;
  logic [15:0]                run_count_next;
  logic [15:0]                fan_hours_next;

  // Access completes only on an enabled edge, so ready simply follows the enable
  assign pready  = clk_en;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg & psel & penable;

  // Write decode; reset bits of the control word act as one-shot strobes
  assign wr_en         = psel & penable & pwrite & clk_en;
  assign wr_ctrl       = wr_en & idx_hit(paddr, fhm_pkg::IDX_CTRL);
  assign wr_op_preset  = wr_en & idx_hit(paddr, fhm_pkg::IDX_OP_PRESET);
  assign wr_fan_preset = wr_en & idx_hit(paddr, fhm_pkg::IDX_FAN_PRESET);
  assign run_clr       = wr_ctrl & pwdata[fhm_pkg::CTRL_RUNCLR_BIT];
  assign cap_clr       = wr_ctrl & pwdata[fhm_pkg::CTRL_CAPCLR_BIT];
  assign relay_clr     = wr_ctrl & pwdata[fhm_pkg::CTRL_RLYCLR_BIT];
  assign switch_clr    = wr_ctrl & pwdata[fhm_pkg::CTRL_SWCLR_BIT];

  // Hour advance per count mode; fan hours only while the fan turns
  assign op_inc  = hour_tick & ((mode_reg == fhm_pkg::FHM_MODE_POWER) | run_active);
  assign fan_inc = hour_tick & fan_running;

  // Count mode setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= fhm_pkg::FHM_MODE_POWER;
    end else if (wr_ctrl) begin
      mode_reg <= fhm_pkg::fhm_count_mode_t'(pwdata[fhm_pkg::CTRL_MODE_BIT]);
    end
  end

  // Fault history shift register, newest entry at position zero
  generate
    for (genvar i = 0; i < fhm_pkg::HIST_DEPTH; i++) begin : g_hist
      // Head and tail split at elaboration so entry zero never names index minus one
      if (i == 0) begin : g_head
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            hist_reg[i] <= 16'h0000;
            hrs_reg[i]  <= 17'h00000;
          end else if (clk_en && fault_valid) begin
            hist_reg[i] <= fault_code;
            hrs_reg[i]  <= op_hours_reg;
          end
        end
      end else begin : g_tail
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            hist_reg[i] <= 16'h0000;
            hrs_reg[i]  <= 17'h00000;
          end else if (clk_en && fault_valid) begin
            hist_reg[i] <= hist_reg[i-1];
            hrs_reg[i]  <= hrs_reg[i-1];
          end
        end
      end
    end
  endgenerate

  // Operation hours next value; a preset lands first, a tick in the same cycle still counts
  always_comb begin
    op_hours_next = op_hours_reg;
    if (wr_op_preset) begin
      // Out-of-range presets fall back to zero rather than exceed the display limit
      op_hours_next = (pwdata[16:0] > fhm_pkg::OP_HOURS_MAX) ? 17'h00000 : pwdata[16:0];
    end
    if (op_inc) begin
      op_hours_next = (op_hours_next == fhm_pkg::OP_HOURS_MAX) ? 17'h00000 : op_hours_next + 17'h00001;
    end
  end

  // Operation hour register, frozen while the enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_hours_reg <= 17'h00000;
    end else if (clk_en) begin
      op_hours_reg <= op_hours_next;
    end
  end

  // Run command count next value; a command arriving with the clear is kept
  always_comb begin
    run_count_next = run_clr ? 16'h0000 : run_count_reg;
    if (run_cmd_pulse) begin
      run_count_next = run_count_next + 16'h0001;          // natural wrap past 65535
    end
  end

  // Run command counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_count_reg <= 16'h0000;
    end else if (clk_en) begin
      run_count_reg <= run_count_next;
    end
  end

  // Cooling fan hours next value with preset load
  always_comb begin
    fan_hours_next = wr_fan_preset ? pwdata[15:0] : fan_hours_reg;
    if (fan_inc) begin
      fan_hours_next = fan_hours_next + 16'h0001;
    end
  end

  // Cooling fan hour register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_hours_reg <= 16'h0000;
    end else if (clk_en) begin
      fan_hours_reg <= fan_hours_next;
    end
  end

  // Life monitors saturate so a worn part never reads as new
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_life_reg    <= 16'h0000;
      relay_life_reg  <= 16'h0000;
      switch_life_reg <= 16'h0000;
    end else if (clk_en) begin
      if (cap_clr) begin
        cap_life_reg <= {15'h0000, cap_wear_tick};
      end else if (cap_wear_tick && cap_life_reg != fhm_pkg::LIFE_MAX) begin
        cap_life_reg <= cap_life_reg + 16'h0001;
      end
      if (relay_clr) begin
        relay_life_reg <= {15'h0000, relay_wear_tick};
      end else if (relay_wear_tick && relay_life_reg != fhm_pkg::LIFE_MAX) begin
        relay_life_reg <= relay_life_reg + 16'h0001;
      end
      if (switch_clr) begin
        switch_life_reg <= {15'h0000, switch_wear_tick};
      end else if (switch_wear_tick && switch_life_reg != fhm_pkg::LIFE_MAX) begin
        switch_life_reg <= switch_life_reg + 16'h0001;
      end
    end
  end

  // Read mux, narrow values zero-extended
  always_comb begin
    rdata_next = 32'h0000_0000;
    hit_next   = 1'b0;
    if (idx_hit(paddr, fhm_pkg::IDX_OP_HOURS)) begin
      rdata_next = {15'h0000, op_hours_reg};
      hit_next   = 1'b1;
    end
    if (idx_hit(paddr, fhm_pkg::IDX_FAN_HOURS)) begin
      rdata_next = {16'h0000, fan_hours_reg};
      hit_next   = 1'b1;
    end
    if (idx_hit(paddr, fhm_pkg::IDX_RUN_COUNT)) begin
      rdata_next = {16'h0000, run_count_reg};
      hit_next   = 1'b1;
    end
    if (idx_hit(paddr, fhm_pkg::IDX_CAP_LIFE)) begin
      rdata_next = {16'h0000, cap_life_reg};
      hit_next   = 1'b1;
    end
    if (idx_hit(paddr, fhm_pkg::IDX_RELAY_LIFE)) begin
      rdata_next = {16'h0000, relay_life_reg};
      hit_next   = 1'b1;
    end
    if (idx_hit(paddr, fhm_pkg::IDX_SWITCH_LIFE)) begin
      rdata_next = {16'h0000, switch_life_reg};
      hit_next   = 1'b1;
    end
    if (idx_hit(paddr, fhm_pkg::IDX_CTRL)) begin
      rdata_next = {31'h0000_0000, mode_reg};
      hit_next   = 1'b1;
    end
    // Presets are write-only settings; they read back as zero
    if (idx_hit(paddr, fhm_pkg::IDX_OP_PRESET) || idx_hit(paddr, fhm_pkg::IDX_FAN_PRESET)) begin
      hit_next = 1'b1;
    end
    for (int i = 0; i < fhm_pkg::HIST_DEPTH; i++) begin
      if (idx_hit(paddr, fhm_pkg::HIST_IDX[i])) begin
        rdata_next = {16'h0000, hist_reg[i]};
        hit_next   = 1'b1;
      end
      if (idx_hit(paddr, fhm_pkg::HRS_IDX[i])) begin
        rdata_next = {15'h0000, hrs_reg[i]};
        hit_next   = 1'b1;
      end
    end
    for (int i = 0; i < fhm_pkg::ALT_DEPTH; i++) begin
      if (idx_hit(paddr, fhm_pkg::HIST_ALT_IDX[i])) begin
        rdata_next = {16'h0000, hist_reg[i]};
        hit_next   = 1'b1;
      end
      if (idx_hit(paddr, fhm_pkg::HRS_ALT_IDX[i])) begin
        rdata_next = {15'h0000, hrs_reg[i]};
        hit_next   = 1'b1;
      end
    end
  end

  // Read data and error captured in the setup cycle, held through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (clk_en && psel && !penable) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rdata_next;
      pslverr_reg <= !hit_next;
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_hist_new;
    clk_en && fault_valid |=> hist_reg[0] == $past(fault_code);
  endproperty
  a_hist_new: assert property (p_hist_new) else $error("newest fault code not stored");

  property p_hrs_capture;
    clk_en && fault_valid |=> hrs_reg[0] == $past(op_hours_reg);
  endproperty
  a_hrs_capture: assert property (p_hrs_capture) else $error("fault hours not captured");

  property p_hist_shift;
    clk_en && fault_valid |=> (hist_reg[9] == $past(hist_reg[8])) && (hrs_reg[1] == $past(hrs_reg[0]));
  endproperty
  a_hist_shift: assert property (p_hist_shift) else $error("history did not shift");

  property p_op_preset;
    clk_en && wr_op_preset && !op_inc && pwdata[16:0] <= fhm_pkg::OP_HOURS_MAX
      |=> op_hours_reg == $past(pwdata[16:0]);
  endproperty
  a_op_preset: assert property (p_op_preset) else $error("hour preset not loaded");

  property p_op_mode;
    clk_en && hour_tick && mode_reg == fhm_pkg::FHM_MODE_RUN && !run_active && !wr_op_preset
      |=> $stable(op_hours_reg);
  endproperty
  a_op_mode: assert property (p_op_mode) else $error("hours counted with no run command");

  property p_op_wrap;
    clk_en && op_inc && !wr_op_preset && op_hours_reg == fhm_pkg::OP_HOURS_MAX |=> op_hours_reg == 17'h00000;
  endproperty
  a_op_wrap: assert property (p_op_wrap) else $error("hour counter did not wrap at limit");

  property p_run_wrap;
    clk_en && run_cmd_pulse && !run_clr && run_count_reg == fhm_pkg::CNT16_MAX |=> run_count_reg == 16'h0000;
  endproperty
  a_run_wrap: assert property (p_run_wrap) else $error("run counter did not wrap");

  property p_run_clear;
    clk_en && run_clr |=> run_count_reg == {15'h0000, $past(run_cmd_pulse)};
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run counter not cleared");

  property p_fan_count;
    clk_en && fan_inc && !wr_fan_preset |=> fan_hours_reg == $past(fan_hours_reg) + 16'h0001;
  endproperty
  a_fan_count: assert property (p_fan_count) else $error("fan hours did not advance");

  property p_fan_preset;
    clk_en && wr_fan_preset && !fan_inc |=> fan_hours_reg == $past(pwdata[15:0]);
  endproperty
  a_fan_preset: assert property (p_fan_preset) else $error("fan preset not loaded");

  property p_cap_clear;
    clk_en && cap_clr && !cap_wear_tick |=> cap_life_reg == 16'h0000;
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("capacitor monitor not cleared");

  property p_relay_clear;
    clk_en && relay_clr && !relay_wear_tick |=> relay_life_reg == 16'h0000;
  endproperty
  a_relay_clear: assert property (p_relay_clear) else $error("relay monitor not cleared");

  property p_switch_step;
    clk_en && switch_wear_tick && !switch_clr && switch_life_reg < fhm_pkg::LIFE_MAX
      |=> switch_life_reg == $past(switch_life_reg) + 16'h0001;
  endproperty
  a_switch_step: assert property (p_switch_step) else $error("switch monitor missed a step");

endmodule // fhm_monitor_bank

// >>> hdl/fhm_pkg.sv
/*
  Constants for the fault history and maintenance monitor bank: register
  indices, field positions, counter limits and the count-mode encoding.
  Assumes an APB slave with 32-bit data where the byte address of a
  register is four times its index.
*/
package fhm_pkg;

  // Bus shape, history depths and field widths
  localparam int          ADDR_W      = 18;
  localparam int          DATA_W      = 32;
  localparam int          IDX_W       = 16;
  localparam int          HIST_DEPTH  = 10;
  localparam int          ALT_DEPTH   = 4;
  localparam int          CODE_W      = 16;
  localparam int          OPH_W       = 17;
  localparam int          CNT_W       = 16;

  // Counter limits
  localparam logic [16:0] OP_HOURS_MAX = 17'h1869F;   // 99999 hours
  localparam logic [15:0] CNT16_MAX    = 16'hFFFF;    // 65535
  localparam logic [15:0] LIFE_MAX     = 16'hFFFF;    // Life monitors saturate here

  // Maintenance monitor indices
  localparam logic [15:0] IDX_OP_HOURS    = 16'h004C;
  localparam logic [15:0] IDX_FAN_HOURS   = 16'h0067;
  localparam logic [15:0] IDX_RUN_COUNT   = 16'h0076;
  localparam logic [15:0] IDX_CAP_LIFE    = 16'h007C;
  localparam logic [15:0] IDX_RELAY_LIFE  = 16'h07D6;
  localparam logic [15:0] IDX_SWITCH_LIFE = 16'h07D7;

  // Setting registers
  localparam logic [15:0] IDX_CTRL        = 16'h0900;
  localparam logic [15:0] IDX_OP_PRESET   = 16'h0901;
  localparam logic [15:0] IDX_FAN_PRESET  = 16'h0902;

  // Fault history indices, most recent first
  localparam logic [15:0] HIST_IDX [HIST_DEPTH] = '{
    16'h0090, 16'h0091, 16'h0092, 16'h0093, 16'h0804,
    16'h0805, 16'h0806, 16'h0807, 16'h0808, 16'h0809};
  localparam logic [15:0] HIST_ALT_IDX [ALT_DEPTH] = '{
    16'h0800, 16'h0801, 16'h0802, 16'h0803};
  localparam logic [15:0] HRS_IDX [HIST_DEPTH] = '{
    16'h0094, 16'h0095, 16'h0096, 16'h0097, 16'h080E,
    16'h080F, 16'h810E, 16'h811E, 16'h0812, 16'h0813};
  localparam logic [15:0] HRS_ALT_IDX [ALT_DEPTH] = '{
    16'h080A, 16'h080B, 16'h080C, 16'h080D};

  // Control register fields
  localparam int CTRL_MODE_BIT   = 0;
  localparam int CTRL_RUNCLR_BIT = 1;
  localparam int CTRL_CAPCLR_BIT = 2;
  localparam int CTRL_RLYCLR_BIT = 3;
  localparam int CTRL_SWCLR_BIT  = 4;

  // Operation hour count mode
  typedef enum logic [0:0] {
    FHM_MODE_POWER = 1'b0,
    FHM_MODE_RUN   = 1'b1
  } fhm_count_mode_t;

endpackage

// >>> testbench/tb.sv
/*
  Self-checking bench for the fault history and maintenance monitor bank.
  Assumes the APB slave answers through pready and that events are sampled on pclk.
*/
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic rd; logic err; logic [31:0] data;} fhm_note_t;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        fault_valid, hour_tick, run_active, run_cmd_pulse, fan_running;
  logic        cap_wear_tick, relay_wear_tick, switch_wear_tick;
  logic [15:0] fault_code;
  logic [15:0] codes [11];
  logic [15:0] life_idx [3];
  fhm_note_t   notes [$];
  fhm_note_t   nt;
  int          failures, n_compared, seed, k, n;

  fhm_monitor_bank dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_valid(fault_valid), .fault_code(fault_code), .hour_tick(hour_tick), .run_active(run_active),
    .run_cmd_pulse(run_cmd_pulse), .fan_running(fan_running), .cap_wear_tick(cap_wear_tick),
    .relay_wear_tick(relay_wear_tick), .switch_wear_tick(switch_wear_tick));

  // Free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic wrap_up();
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_err(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the expected answer is queued for the watcher
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [1:0] lo, input logic [31:0] wd,
                     input logic [31:0] exp_d, input logic exp_e);
    int w;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, lo};
    pwdata  <= wd;
    notes.push_back({~wr, exp_e, exp_d});
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 2'h0, 32'h0, exp, 1'b0);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] val);
    apb(1'b1, idx, 2'h0, val, 32'h0, 1'b0);
  endtask

  // One-cycle event pulses, n of them, with an idle cycle between
  task automatic ev(input int which, input int cnt);
    repeat (cnt) begin
      @(posedge pclk);
      case (which)
        0: hour_tick <= 1'b1;
        1: fault_valid <= 1'b1;
        2: cap_wear_tick <= 1'b1;
        3: relay_wear_tick <= 1'b1;
        default: switch_wear_tick <= 1'b1;
      endcase
      @(posedge pclk);
      {hour_tick, fault_valid, cap_wear_tick, relay_wear_tick, switch_wear_tick} <= 5'h00;
    end
  endtask

  // Watcher: every completed transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        failures++;
        $display("mismatch t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
      end else begin
        nt = notes.pop_front();
        cmp_err(pslverr, nt.err);
        if (nt.rd && !nt.err) cmp_data(prdata, nt.data);
      end
    end
  end

  // Hang guard
  initial begin
    repeat (99000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial begin
    {presetn, psel, penable, pwrite, fault_valid, hour_tick, run_active, run_cmd_pulse} = 8'h00;
    {fan_running, cap_wear_tick, relay_wear_tick, switch_wear_tick} = 4'h0;
    clk_en = 1'b1;
    paddr = 18'h00000;
    pwdata = 32'h0;
    fault_code = 16'h0000;
    failures = 0;
    n_compared = 0;
    seed = 32'hD32851B4;
    life_idx = '{fhm_pkg::IDX_CAP_LIFE, fhm_pkg::IDX_RELAY_LIFE, fhm_pkg::IDX_SWITCH_LIFE};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(fhm_pkg::IDX_OP_HOURS, 32'h0);
    // Eleven faults, one hour apart, so the oldest falls off the end
    for (k = 0; k < 11; k++) begin
      codes[k] = 16'($random(seed));
      fault_code <= codes[k];
      ev(1, 1);
      ev(0, 1);
    end
    for (k = 0; k < 10; k++) begin
      rd(fhm_pkg::HIST_IDX[k], {16'h0, codes[10-k]});
      rd(fhm_pkg::HRS_IDX[k], 32'(10 - k));
      if (k < 4) rd(fhm_pkg::HIST_ALT_IDX[k], {16'h0, codes[10-k]});
      if (k < 4) rd(fhm_pkg::HRS_ALT_IDX[k], 32'(10 - k));
    end
    rd(fhm_pkg::IDX_OP_HOURS, 32'd11);
    // Write to a monitor is ignored; unmapped and misaligned addresses fail
    wr(fhm_pkg::IDX_OP_HOURS, 32'h1234);
    rd(fhm_pkg::IDX_OP_HOURS, 32'd11);
    apb(1'b0, 16'h0000, 2'h0, 32'h0, 32'h0, 1'b1);
    apb(1'b0, fhm_pkg::IDX_OP_HOURS, 2'h2, 32'h0, 32'h0, 1'b1);
    // Out-of-range preset falls back to zero
    wr(fhm_pkg::IDX_OP_PRESET, 32'd100000);
    rd(fhm_pkg::IDX_OP_HOURS, 32'h0);
    // Preset near the top, then roll over
    wr(fhm_pkg::IDX_OP_PRESET, 32'd99998);
    rd(fhm_pkg::IDX_OP_HOURS, 32'd99998);
    ev(0, 1);
    rd(fhm_pkg::IDX_OP_HOURS, 32'd99999);
    ev(0, 1);
    rd(fhm_pkg::IDX_OP_HOURS, 32'h0);
    // Run-only counting, and a frozen clock enable
    wr(fhm_pkg::IDX_CTRL, 32'h1);
    rd(fhm_pkg::IDX_CTRL, 32'h1);
    ev(0, 1);
    rd(fhm_pkg::IDX_OP_HOURS, 32'h0);
    run_active <= 1'b1;
    ev(0, 1);
    rd(fhm_pkg::IDX_OP_HOURS, 32'h1);
    clk_en <= 1'b0;
    ev(0, 1);
    clk_en <= 1'b1;
    rd(fhm_pkg::IDX_OP_HOURS, 32'h1);
    run_active <= 1'b0;
    wr(fhm_pkg::IDX_CTRL, 32'h0);
    ev(0, 1);
    rd(fhm_pkg::IDX_OP_HOURS, 32'h2);
    // Fan hours from preset through the wrap
    wr(fhm_pkg::IDX_FAN_PRESET, 32'hFFFE);
    rd(fhm_pkg::IDX_FAN_HOURS, 32'hFFFE);
    fan_running <= 1'b1;
    ev(0, 1);
    rd(fhm_pkg::IDX_FAN_HOURS, 32'hFFFF);
    ev(0, 1);
    rd(fhm_pkg::IDX_FAN_HOURS, 32'h0);
    fan_running <= 1'b0;
    ev(0, 1);
    rd(fhm_pkg::IDX_FAN_HOURS, 32'h0);
    // Run commands every cycle: 65537 of them wrap to one
    @(posedge pclk);
    run_cmd_pulse <= 1'b1;
    repeat (65537) @(posedge pclk);
    run_cmd_pulse <= 1'b0;
    rd(fhm_pkg::IDX_RUN_COUNT, 32'h1);
    wr(fhm_pkg::IDX_CTRL, 32'h2);
    rd(fhm_pkg::IDX_RUN_COUNT, 32'h0);
    // Life monitors: random wear, then their own clear strobe
    for (k = 0; k < 3; k++) begin
      n = 1 + ($unsigned($random(seed)) % 6);
      ev(2 + k, n);
      rd(life_idx[k], 32'(n));
      wr(fhm_pkg::IDX_CTRL, 32'h4 << k);
      rd(life_idx[k], 32'h0);
    end
    // Powered mode kept counting through the fan ticks; a mid-run reset clears it all
    rd(fhm_pkg::IDX_OP_HOURS, 32'd5);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(fhm_pkg::HIST_IDX[0], 32'h0);
    rd(fhm_pkg::HRS_IDX[0], 32'h0);
    rd(fhm_pkg::IDX_OP_HOURS, 32'h0);
    repeat (4) @(posedge pclk);
    wrap_up();
  end
endmodule // tb
